// ---- pkg/i2c_tx_pkg.sv ----
// constants and helpers shared by the transmit data path
package i2c_tx_pkg;
  // transmit byte holding register layout
  localparam int HOLD_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam logic [7:0] HOLD_UPPER_ZERO = 8'h00;
  // byte length field and bit counter
  localparam int LEN_FIELD_W = 3;
  localparam int CNT_W = 4;
  localparam logic [2:0] LEN_FIELD_FULL = 3'h0;
  localparam logic [3:0] FULL_BYTE_BITS = 4'h8;
  // positions of the events that cross from the link domain
  localparam int EV_NACK = 0;
  localparam int EV_STOP = 1;
  localparam int EV_RSTART = 2;
  localparam int EV_ADDR_OTHER = 3;
  localparam int EV_ADDR_OWN = 4;
  localparam int EV_DONE = 5;
  localparam int EV_W = 6;

  // number of bits in a byte for a given length field, zero meaning eight
  function automatic logic [3:0] bits_of(input logic [2:0] len_field);
    bits_of = (len_field == LEN_FIELD_FULL) ? FULL_BYTE_BITS : {1'b0, len_field};
  endfunction
endpackage

// ---- hdl/pulse_sync.sv ----
// toggle based crossing of a vector of one-cycle events
`timescale 1ns/1ps
module pulse_sync #(
  parameter int W = 1
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_ce,
  input wire logic [W-1:0] src_pulse,
  input wire logic dst_clk,
  input wire logic dst_rst,
  input wire logic dst_ce,
  output logic [W-1:0] dst_pulse
);
  logic [W-1:0] tog_r;
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  // source side flips a level per event
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      tog_r <= '0;
    end else if (src_ce) begin
      tog_r <= tog_r ^ src_pulse;
    end
  end

  // two flops, the first read only by the second
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else if (dst_ce) begin
      meta_r <= tog_r;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // one pulse per level change seen
  assign dst_pulse = sync_r ^ last_r;
endmodule

// ---- hdl/tx_shifter.sv ----
// transmit shifter on the link clock, drives the data line low for zeros
`timescale 1ns/1ps
module tx_shifter (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic [3:0] load_len,
  output logic sda_oe,
  output logic done
);
  logic [7:0] transmit_shifter_r;
  logic [3:0] left_r;
  logic [3:0] pad;

  assign pad = i2c_tx_pkg::FULL_BYTE_BITS - load_len;

  // load aligns the top programmed bit to bit 7, then shift out msb first
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      transmit_shifter_r <= 8'h00;
      left_r <= 4'h0;
    end else if (load) begin
      transmit_shifter_r <= load_data << pad;
      left_r <= load_len;
    end else if (left_r != 4'h0) begin
      transmit_shifter_r <= {transmit_shifter_r[6:0], 1'b0};
      left_r <= left_r - 4'h1;
    end
  end

  // one bit per link edge, released when idle
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sda_oe <= 1'b0;
      done <= 1'b0;
    end else begin
      sda_oe <= (left_r != 4'h0) && !load && !transmit_shifter_r[7];
      done <= (left_r == 4'h1) && !load;
    end
  end

  property p_idle_release;
    @(posedge link_clk) disable iff (link_rst)
    (left_r == 4'h0) |=> !sda_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("line driven while idle");

  property p_bit_value;
    @(posedge link_clk) disable iff (link_rst)
    (left_r != 4'h0 && !load) |=> (sda_oe == !$past(transmit_shifter_r[7]));
  endproperty
  a_bit_value: assert property (p_bit_value) else $error("wrong bit on line");

  property p_bit_count;
    @(posedge link_clk) disable iff (link_rst)
    (load && load_len == 4'h3) |=> (left_r == 4'h3) ##3 (left_r == 4'h0);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("short byte length wrong");
endmodule

// ---- hdl/i2c_transmit_data_path.sv ----
// transmit data path: holding register, copy to shifter, slave flag
`timescale 1ns/1ps
// Operation
// - holding register is 16 bits, low byte takes a 1 to 8 bit byte.
// - a written byte is copied into the hidden transmit shifter.
// - the shifter moves its contents out on the data line bit by bit.
// - the shifter cannot be read or written by processor or DMA.
// - bits 15 to 8 read zero and writes to them are dropped.
// - 7-bit mode clears slave flag on nack, stop or repeated start.
// - 10-bit mode clears slave flag on nack, stop or foreign address.
// - byte length field sets how many bits each byte holds.
// - expanded address select low means 7-bit, high means 10-bit.
module i2c_transmit_data_path (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sys_ce,
  input wire logic holding_wr,
  input wire logic [15:0] holding_wdata,
  output logic [15:0] holding_rdata,
  input wire logic [2:0] byte_length_field,
  input wire logic expanded_address_select,
  output logic transmit_ready_flag,
  output logic shifter_busy,
  output logic addressed_as_slave_flag,
  input wire logic link_clk,
  input wire logic nack_rx,
  input wire logic stop_rx,
  input wire logic rstart_rx,
  input wire logic addr_other_rx,
  input wire logic addr_own_rx,
  output logic sda_o,
  output logic sda_oe
);
  // system domain state
  logic [7:0] hold_data_r;
  logic hold_full_r;
  logic [7:0] launch_data_r;
  logic [3:0] launch_len_r;
  logic busy_r;
  logic aas_r;
  logic copy_go;
  logic aas_clear;
  logic [i2c_tx_pkg::EV_W-1:0] ev_sys;

  // link reset request and its acknowledge seen back
  logic link_rst_req_r;
  logic ack_meta_r;
  logic ack_sync_r;

  // link domain state
  logic rst_meta_r;
  logic link_rst_r;
  logic load_link;
  logic done_link;
  logic [i2c_tx_pkg::EV_W-1:0] ev_link;

  // a short reset may fall between two link edges, so the request
  // stays up until the link side is seen in reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link_rst_req_r <= 1'b1;
    end else if (sys_ce && ack_sync_r) begin
      link_rst_req_r <= 1'b0;
    end
  end

  // link reset state brought back through two flops
  always_ff @(posedge sys_clk) begin
    if (sys_ce) begin
      ack_meta_r <= link_rst_r;
      ack_sync_r <= ack_meta_r;
    end
  end

  // reset request brought into the link domain through two flops
  always_ff @(posedge link_clk) begin
    rst_meta_r <= link_rst_req_r;
    link_rst_r <= rst_meta_r;
  end

  // holding register, only the low byte is stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_data_r <= i2c_tx_pkg::HOLD_RESET[7:0];
    end else if (sys_ce && holding_wr) begin
      hold_data_r <= holding_wdata[7:0];
    end
  end

  // read back shows the held byte, upper byte always zero
  assign holding_rdata = {i2c_tx_pkg::HOLD_UPPER_ZERO, hold_data_r};

  // copy starts when a byte is held and the shifter is free
  assign copy_go = sys_ce && hold_full_r && !busy_r;

  // full flag, a new write wins over the copy that empties it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_full_r <= 1'b0;
    end else if (sys_ce) begin
      if (holding_wr) begin
        hold_full_r <= 1'b1;
      end else if (copy_go) begin
        hold_full_r <= 1'b0;
      end
    end
  end

  // ready while the holding register is free for a new byte
  assign transmit_ready_flag = !hold_full_r;

  // launch copy held stable until the link side reports the byte sent
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      launch_data_r <= 8'h00;
      launch_len_r <= i2c_tx_pkg::FULL_BYTE_BITS;
    end else if (copy_go) begin
      launch_data_r <= hold_data_r;
      launch_len_r <= i2c_tx_pkg::bits_of(byte_length_field);
    end
  end

  // busy from copy until the done event returns
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (sys_ce) begin
      if (copy_go) begin
        busy_r <= 1'b1;
      end else if (ev_sys[i2c_tx_pkg::EV_DONE]) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign shifter_busy = busy_r;

  // clear causes depend on the addressing mode
  always_comb begin
    aas_clear = ev_sys[i2c_tx_pkg::EV_NACK] || ev_sys[i2c_tx_pkg::EV_STOP];
    if (expanded_address_select) begin
      aas_clear = aas_clear || ev_sys[i2c_tx_pkg::EV_ADDR_OTHER];
    end else begin
      aas_clear = aas_clear || ev_sys[i2c_tx_pkg::EV_RSTART];
    end
  end

  // addressed as slave flag, an own address match wins over a clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aas_r <= 1'b0;
    end else if (sys_ce) begin
      if (ev_sys[i2c_tx_pkg::EV_ADDR_OWN]) begin
        aas_r <= 1'b1;
      end else if (aas_clear) begin
        aas_r <= 1'b0;
      end
    end
  end

  assign addressed_as_slave_flag = aas_r;

  // load event to the link domain, data stays stable while busy
  pulse_sync #(
    .W(1)
  ) u_load_sync (
    .src_clk(sys_clk),
    .src_rst(rst),
    .src_ce(sys_ce),
    .src_pulse(copy_go),
    .dst_clk(link_clk),
    .dst_rst(link_rst_r),
    .dst_ce(1'b1),
    .dst_pulse(load_link)
  );

  // shifter has no bus path, only the launch copy reaches it
  tx_shifter u_shifter (
    .link_clk(link_clk),
    .link_rst(link_rst_r),
    .load(load_link),
    .load_data(launch_data_r),
    .load_len(launch_len_r),
    .sda_oe(sda_oe),
    .done(done_link)
  );

  // open drain: only ever pulls low
  assign sda_o = 1'b0;

  // bus events and byte done gathered for the crossing
  always_comb begin
    ev_link = '0;
    ev_link[i2c_tx_pkg::EV_NACK] = nack_rx;
    ev_link[i2c_tx_pkg::EV_STOP] = stop_rx;
    ev_link[i2c_tx_pkg::EV_RSTART] = rstart_rx;
    ev_link[i2c_tx_pkg::EV_ADDR_OTHER] = addr_other_rx;
    ev_link[i2c_tx_pkg::EV_ADDR_OWN] = addr_own_rx;
    ev_link[i2c_tx_pkg::EV_DONE] = done_link;
  end

  // link events into the system domain
  pulse_sync #(
    .W(i2c_tx_pkg::EV_W)
  ) u_event_sync (
    .src_clk(link_clk),
    .src_rst(link_rst_r),
    .src_ce(1'b1),
    .src_pulse(ev_link),
    .dst_clk(sys_clk),
    .dst_rst(rst),
    .dst_ce(sys_ce),
    .dst_pulse(ev_sys)
  );

  // checks on the system side
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_upper_zero;
    holding_wr |=> (holding_rdata[15:8] == 8'h00);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");

  property p_write_low;
    (sys_ce && holding_wr) |=> (holding_rdata[7:0] == $past(holding_wdata[7:0]));
  endproperty
  a_write_low: assert property (p_write_low) else $error("low byte not stored");

  property p_write_not_ready;
    (sys_ce && holding_wr) |=> !transmit_ready_flag;
  endproperty
  a_write_not_ready: assert property (p_write_not_ready) else $error("ready after write");

  property p_copy_ready;
    (copy_go && !holding_wr) |=> transmit_ready_flag && shifter_busy;
  endproperty
  a_copy_ready: assert property (p_copy_ready) else $error("ready not raised on copy");

  property p_copy_data;
    copy_go |=> (launch_data_r == $past(hold_data_r));
  endproperty
  a_copy_data: assert property (p_copy_data) else $error("wrong byte copied");

  property p_copy_len;
    copy_go |=> (launch_len_r == i2c_tx_pkg::bits_of($past(byte_length_field)));
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("wrong byte length");

  property p_clear_7bit;
    (sys_ce && !expanded_address_select && !ev_sys[i2c_tx_pkg::EV_ADDR_OWN] &&
     (ev_sys[i2c_tx_pkg::EV_NACK] || ev_sys[i2c_tx_pkg::EV_STOP] ||
      ev_sys[i2c_tx_pkg::EV_RSTART])) |=> !addressed_as_slave_flag;
  endproperty
  a_clear_7bit: assert property (p_clear_7bit) else $error("flag kept in 7-bit mode");

  property p_clear_10bit;
    (sys_ce && expanded_address_select && !ev_sys[i2c_tx_pkg::EV_ADDR_OWN] &&
     (ev_sys[i2c_tx_pkg::EV_NACK] || ev_sys[i2c_tx_pkg::EV_STOP] ||
      ev_sys[i2c_tx_pkg::EV_ADDR_OTHER])) |=> !addressed_as_slave_flag;
  endproperty
  a_clear_10bit: assert property (p_clear_10bit) else $error("flag kept in 10-bit mode");

  property p_rstart_10bit_keeps;
    (sys_ce && expanded_address_select && addressed_as_slave_flag &&
     ev_sys == (6'h01 << i2c_tx_pkg::EV_RSTART)) |=> addressed_as_slave_flag;
  endproperty
  a_rstart_10bit_keeps: assert property (p_rstart_10bit_keeps) else $error("10-bit rstart cleared");

  property p_own_sets;
    (sys_ce && ev_sys[i2c_tx_pkg::EV_ADDR_OWN]) |=> addressed_as_slave_flag;
  endproperty
  a_own_sets: assert property (p_own_sets) else $error("flag not set on own address");

  property p_busy_until_done;
    (busy_r && !ev_sys[i2c_tx_pkg::EV_DONE]) |=> busy_r && $stable(launch_data_r);
  endproperty
  a_busy_until_done: assert property (p_busy_until_done) else $error("launch changed while busy");

  property p_rst_req_held;
    (link_rst_req_r && !ack_sync_r) |=> link_rst_req_r;
  endproperty
  a_rst_req_held: assert property (p_rst_req_held) else $error("link reset dropped early");

  property p_rdata_stable;
    !(sys_ce && holding_wr) |=> $stable(holding_rdata);
  endproperty
  a_rdata_stable: assert property (p_rdata_stable) else $error("read view moved without write");

  property p_flag_quiet;
    (!sys_ce || ev_sys == 6'h00) |=> $stable(addressed_as_slave_flag);
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag moved without event");

  property p_write_with_copy;
    (copy_go && holding_wr) |=> !transmit_ready_flag && shifter_busy;
  endproperty
  a_write_with_copy: assert property (p_write_with_copy) else $error("write lost at copy");

  c_copy: cover property (copy_go);
  c_short_copy: cover property (copy_go && byte_length_field != 3'h0);
  c_done: cover property (busy_r && sys_ce && ev_sys[i2c_tx_pkg::EV_DONE]);
  c_aas_set: cover property (!aas_r ##1 aas_r);
  c_aas_clear_10: cover property (expanded_address_select && aas_r ##1 !aas_r);
endmodule

// ---- verification/i2c_far_side.sv ----
// far side of the serial line: pull-up and link event source
`timescale 1ns/1ps
module i2c_far_side (
  input wire logic link_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  output logic sda_line,
  output logic nack_rx,
  output logic stop_rx,
  output logic rstart_rx,
  output logic addr_other_rx,
  output logic addr_own_rx
);
  logic [4:0] ev_r = 5'h00;

  // released line rises through the pull-up, only a driven low wins
  assign sda_line = sda_oe ? sda_o : 1'b1;
  // one event line per bus condition
  assign nack_rx = ev_r[0];
  assign stop_rx = ev_r[1];
  assign rstart_rx = ev_r[2];
  assign addr_other_rx = ev_r[3];
  assign addr_own_rx = ev_r[4];

  // one link cycle pulse of the chosen condition
  task automatic send_event(input int k);
    @(posedge link_clk);
    ev_r <= 5'h01 << k;
    @(posedge link_clk);
    ev_r <= 5'h00;
  endtask
endmodule

// ---- verification/i2c_transmit_data_path_tb.sv ----
// self-checking bench for the transmit data path
`timescale 1ns/1ps
module i2c_transmit_data_path_tb;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic sys_ce = 1'b1;
  logic holding_wr = 1'b0;
  logic [15:0] holding_wdata = 16'h0000;
  logic [2:0] byte_length_field = 3'h0;
  logic expanded_address_select = 1'b0;
  logic [15:0] holding_rdata;
  logic transmit_ready_flag, shifter_busy, addressed_as_slave_flag, sda_o, sda_oe, sda_line;
  logic nack_rx, stop_rx, rstart_rx, addr_other_rx, addr_own_rx;
  logic [11:0] exp_q[$];
  logic seen_q[$];
  logic busy_d = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  // clocks, link clock offset in phase
  always #12.5 sys_clk = ~sys_clk;
  initial begin
    #7.3;
    forever #40 link_clk = ~link_clk;
  end

  i2c_transmit_data_path u_dut (.sys_clk(sys_clk), .rst(rst), .sys_ce(sys_ce),
    .holding_wr(holding_wr), .holding_wdata(holding_wdata), .holding_rdata(holding_rdata),
    .byte_length_field(byte_length_field), .expanded_address_select(expanded_address_select),
    .transmit_ready_flag(transmit_ready_flag), .shifter_busy(shifter_busy),
    .addressed_as_slave_flag(addressed_as_slave_flag), .link_clk(link_clk),
    .nack_rx(nack_rx), .stop_rx(stop_rx), .rstart_rx(rstart_rx),
    .addr_other_rx(addr_other_rx), .addr_own_rx(addr_own_rx), .sda_o(sda_o), .sda_oe(sda_oe));

  i2c_far_side u_far (.link_clk(link_clk), .sda_o(sda_o), .sda_oe(sda_oe),
    .sda_line(sda_line), .nack_rx(nack_rx), .stop_rx(stop_rx), .rstart_rx(rstart_rx),
    .addr_other_rx(addr_other_rx), .addr_own_rx(addr_own_rx));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_sys(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // set the length first, then write the byte and read it back
  task automatic write_byte(input logic [15:0] d, input logic [2:0] len);
    @(posedge sys_clk);
    byte_length_field <= len;
    @(posedge sys_clk);
    holding_wr <= 1'b1;
    holding_wdata <= d;
    @(posedge sys_clk);
    holding_wr <= 1'b0;
    @(negedge sys_clk);
    check("readback", holding_rdata, {8'h00, d[7:0]});
  endtask

  // wait, bounded, until every noted byte has left
  task automatic drain();
    for (int i = 0; i < 800 && (exp_q.size() != 0 || shifter_busy); i++) @(posedge sys_clk);
    wait_sys(2);
    check("drained", 16'(exp_q.size()), 16'h0000);
  endtask

  // the n bits, msb first, somewhere in the window, line high elsewhere
  function automatic logic frame_ok(input logic [11:0] e);
    int n;
    logic ok;
    n = e[11:8];
    for (int o = 0; o + n <= seen_q.size(); o++) begin
      ok = 1'b1;
      for (int i = 0; i < seen_q.size(); i++) begin
        if (i >= o && i < o + n) begin
          if (seen_q[i] !== e[n - 1 - (i - o)]) ok = 1'b0;
        end else if (seen_q[i] !== 1'b1) ok = 1'b0;
      end
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction

  // sample the line mid-bit while a byte is in flight
  always @(negedge link_clk) begin
    if (shifter_busy) seen_q.push_back(sda_line);
  end

  // at the end of each byte compare with the oldest note
  always @(negedge sys_clk) begin
    busy_d <= shifter_busy;
    if (busy_d && !shifter_busy && !rst) begin
      if (exp_q.size() == 0) check("extra byte", 16'h0001, 16'h0000);
      else check("serial byte", {15'h0000, frame_ok(exp_q.pop_front())}, 16'h0001);
      seen_q.delete();
    end
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    logic [15:0] d;
    int n;
    void'($urandom(28));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_sys(12);
    check("reset rdata", holding_rdata, 16'h0000);
    check("reset ready", transmit_ready_flag, 16'h0001);
    check("reset flag", addressed_as_slave_flag, 16'h0000);
    check("reset line", sda_oe, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      n = (k == 0) ? 8 : k;
      d = $urandom;
      d[7:0] = d[7:0] & ((8'h01 << n) - 8'h01);
      exp_q.push_back({n[3:0], d[7:0]});
      write_byte(d, k[2:0]);
      drain();
    end
    $display("test lengths done");
    exp_q.push_back({4'h8, 8'h3C});
    exp_q.push_back({4'h8, 8'hA5});
    write_byte(16'hFF3C, 3'h0);
    write_byte(16'h1E5A, 3'h0);
    check("ready held", transmit_ready_flag, 16'h0000);
    write_byte(16'h77A5, 3'h0);
    check("ready held", transmit_ready_flag, 16'h0000);
    drain();
    check("ready free", transmit_ready_flag, 16'h0001);
    $display("test overwrite done");
    @(posedge sys_clk);
    sys_ce <= 1'b0;
    holding_wr <= 1'b1;
    holding_wdata <= 16'h00E7;
    @(posedge sys_clk);
    sys_ce <= 1'b1;
    holding_wr <= 1'b0;
    wait_sys(4);
    check("gated write", holding_rdata, 16'h00A5);
    check("gated busy", shifter_busy, 16'h0000);
    $display("test enable done");
    for (int xa = 0; xa < 2; xa++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge sys_clk);
        expanded_address_select <= xa[0];
        u_far.send_event(4);
        wait_sys(20);
        check("flag set", addressed_as_slave_flag, 16'h0001);
        u_far.send_event(k);
        wait_sys(20);
        check("flag event", addressed_as_slave_flag,
          (k < 2 || (xa == 1 ? k == 3 : k == 2)) ? 16'h0000 : 16'h0001);
      end
    end
    $display("test flag done");
    complete_run();
  end
endmodule
